// File: dbx_pkg.sv
// Package for the phase build-out and crystal trim block of the main timing loop.
// Assumes one synchronous clock domain shared with the reference monitors and the host port.
package dbx_pkg;

  // Master timing
  localparam int unsigned XO_FREQ_KHZ   = 12800;
  localparam int unsigned CLK_PERIOD_PS = 8000;

  // Sources and phase word widths
  localparam int unsigned REF_COUNT = 4;
  localparam int unsigned REF_W     = 2;
  localparam int unsigned PH_W      = 16;

  // Crystal trim register locations and reset value
  localparam logic        TRIM_LO_IDX = 1'b0;
  localparam logic        TRIM_HI_IDX = 1'b1;
  localparam logic [15:0] TRIM_RESET  = 16'h9999;
  localparam logic [15:0] TRIM_ZERO   = 16'h9999;
  localparam int unsigned TRIM_STEP_PPB_X1E4 = 196229;

  // Bandwidth settings
  localparam int unsigned BW_STEPS = 10;
  localparam logic [3:0]  BW_MAX   = 4'h9;

  // Temporary holdover measurement time
  localparam int unsigned MEAS_TIME_NS = 1000;
  localparam int unsigned MEAS_CYCLES  = (MEAS_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned MEAS_W       = 8;

  // Build-out modes
  typedef enum logic [1:0] {
    DBX_PBO_DISABLED,
    DBX_PBO_ENABLED,
    DBX_PBO_FROZEN
  } dbx_mode_t;

  typedef enum logic [1:0] {
    DBX_ACQUIRE,
    DBX_LOCKED,
    DBX_HOLDOVER
  } dbx_fsm_t;

  // Host byte port
  typedef struct packed {
    logic       wr;
    logic       addr;
    logic [7:0] wdata;
  } dbx_host_t;

  // Whole block state
  typedef struct packed {
    dbx_fsm_t          fsm;
    dbx_mode_t         mode;
    logic [REF_W-1:0]  sel;
    logic              sel_ok;
    logic [PH_W-1:0]   offset;
    logic [MEAS_W-1:0] meas_cnt;
    logic [15:0]       trim;
    logic [16:0]       freq_adj;
    logic [7:0]        rdata;
    logic [PH_W-1:0]   loop_phase;
    logic [3:0]        bw;
    logic              holdover;
    logic              event_p;
  } dbx_state_t;

endpackage

// File: dbx_buildout.sv
// Phase build-out, reference switchover, automatic bandwidth and crystal trim of the main timing loop.
// Assumes reference valid flags, lock flag and phase error come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none

module dbx_buildout
  import dbx_pkg::*;
#(
  parameter int unsigned MEAS_LEN = MEAS_CYCLES
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  // Host byte port
  input  wire dbx_host_t             host,
  output logic [7:0]                 host_rdata,
  // Build-out mode and bandwidth settings
  input  wire dbx_mode_t             pbo_mode_req,
  input  wire logic [3:0]            acq_bw,
  input  wire logic [3:0]            locked_bw,
  // Reference monitors and phase detector
  input  wire logic [REF_COUNT-1:0]  ref_valid,
  input  wire logic                  phase_locked,
  input  wire logic [PH_W-1:0]       phase_err,
  // Loop outputs
  output logic [REF_W-1:0]           ref_select,
  output logic                       ref_select_ok,
  output logic [PH_W-1:0]            loop_phase,
  output logic [PH_W-1:0]            pbo_offset,
  output logic                       temp_holdover,
  output logic                       pbo_event,
  output logic [3:0]                 active_bw,
  output logic [15:0]                crystal_trim,
  output logic [16:0]                freq_adjust,
  output var dbx_mode_t              pbo_mode
);

  localparam logic [MEAS_W-1:0] MEAS_LAST = MEAS_W'(MEAS_LEN - 1);

  dbx_state_t s_q;
  dbx_state_t s_d;

  // Lowest valid index wins; a lost selection drops out by its own valid flag
  function automatic logic [REF_W:0] next_ref(input logic [REF_COUNT-1:0] valid);
    logic [REF_W:0] r;
    r = '0;
    for (int i = REF_COUNT - 1; i >= 0; i--) begin
      if (valid[i]) begin
        r = {1'b1, REF_W'(i)};
      end
    end
    return r;
  endfunction

  // Clamp a bandwidth code to the available steps
  function automatic logic [3:0] bw_clamp(input logic [3:0] code);
    return (code > BW_MAX) ? BW_MAX : code;
  endfunction

  // Signed distance of a trim word from the zero-offset setting
  function automatic logic [16:0] trim_offset(input logic [15:0] word);
    return 17'({1'b0, word} - {1'b0, TRIM_ZERO});
  endfunction

  always_comb begin
    logic [REF_W:0] nxt;
    logic           lost;
    logic           trigger;
    nxt     = next_ref(ref_valid);
    lost    = !s_q.sel_ok || !ref_valid[s_q.sel];
    trigger = 1'b0;
    s_d         = s_q;
    s_d.event_p = 1'b0;

    // Two byte locations build one full-range unsigned trim word
    if (host.wr && host.addr == TRIM_LO_IDX) begin
      s_d.trim[7:0] = host.wdata;
    end else if (host.wr && host.addr == TRIM_HI_IDX) begin
      s_d.trim[15:8] = host.wdata;
    end

    // Read back the byte at the presented location
    if (host.addr == TRIM_HI_IDX) begin
      s_d.rdata = s_q.trim[15:8];
    end else begin
      s_d.rdata = s_q.trim[7:0];
    end

    // Signed offset in trim steps of 0.0196229 ppm each
    s_d.freq_adj = trim_offset(s_q.trim);

    // Mode changes; freeze only accepted from enabled
    case (pbo_mode_req)
      DBX_PBO_DISABLED: begin
        s_d.mode = DBX_PBO_DISABLED;
      end
      DBX_PBO_ENABLED: begin
        s_d.mode = DBX_PBO_ENABLED;
        // Enabling while locked starts a build-out as well
        if (s_q.mode == DBX_PBO_DISABLED && s_q.fsm == DBX_LOCKED) begin
          trigger = 1'b1;
        end
      end
      DBX_PBO_FROZEN: begin
        if (s_q.mode != DBX_PBO_DISABLED) begin
          s_d.mode = DBX_PBO_FROZEN;
        end
      end
      default: begin
        s_d.mode = s_q.mode;
      end
    endcase

    // Disabled mode carries no offset
    if (s_d.mode == DBX_PBO_DISABLED) begin
      s_d.offset = '0;
    end

    // Switch to the next priority source on loss
    if (lost && nxt[REF_W]) begin
      s_d.sel    = nxt[REF_W-1:0];
      s_d.sel_ok = 1'b1;
      trigger    = trigger || s_q.sel_ok;
    end else if (lost) begin
      s_d.sel_ok = 1'b0;
    end

    // Lock tracking and the temporary holdover measurement
    case (s_q.fsm)
      DBX_ACQUIRE: begin
        if (phase_locked && s_q.sel_ok) begin
          s_d.fsm = DBX_LOCKED;
        end
      end
      DBX_LOCKED: begin
        if (!phase_locked) begin
          s_d.fsm = DBX_ACQUIRE;
        end
      end
      DBX_HOLDOVER: begin
        // Measure the new input phase against the output
        if (s_q.meas_cnt == MEAS_LAST) begin
          // Offset taken only while still enabled
          if (s_d.mode == DBX_PBO_ENABLED) begin
            s_d.offset = phase_err;
          end
          s_d.holdover = 1'b0;
          s_d.fsm      = DBX_LOCKED;
        end else begin
          s_d.meas_cnt = s_q.meas_cnt + MEAS_W'(1);
        end
      end
      default: begin
        s_d.fsm = DBX_ACQUIRE;
      end
    endcase

    // Build-out only when enabled; frozen ignores events
    if (trigger && s_d.sel_ok && s_d.mode == DBX_PBO_ENABLED) begin
      s_d.event_p  = 1'b1;
      s_d.holdover = 1'b1;
      s_d.meas_cnt = '0;
      s_d.fsm      = DBX_HOLDOVER;
    end else if (trigger && s_d.mode == DBX_PBO_DISABLED) begin
      // Pull back to zero phase error; no measurement left hanging
      s_d.holdover = 1'b0;
      s_d.fsm      = DBX_ACQUIRE;
    end

    // Offset subtracted so the output holds its phase
    if (s_q.holdover) begin
      s_d.loop_phase = '0;
    end else begin
      s_d.loop_phase = PH_W'(phase_err - s_q.offset);
    end

    // Automatic acquisition or locked bandwidth
    if (s_q.fsm == DBX_LOCKED) begin
      s_d.bw = bw_clamp(locked_bw);
    end else begin
      s_d.bw = bw_clamp(acq_bw);
    end
  end

  // Everything timed from the oscillator-derived master clock
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q            <= '0;
      s_q.fsm        <= DBX_ACQUIRE;
      s_q.mode       <= DBX_PBO_ENABLED;
      s_q.trim       <= TRIM_RESET;
      s_q.rdata      <= TRIM_RESET[7:0];
    end else begin
      s_q <= s_d;
    end
  end

  assign host_rdata    = s_q.rdata;
  assign ref_select    = s_q.sel;
  assign ref_select_ok = s_q.sel_ok;
  assign loop_phase    = s_q.loop_phase;
  assign pbo_offset    = s_q.offset;
  assign temp_holdover = s_q.holdover;
  assign pbo_event     = s_q.event_p;
  assign active_bw     = s_q.bw;
  assign crystal_trim  = s_q.trim;
  assign freq_adjust   = s_q.freq_adj;
  assign pbo_mode      = s_q.mode;

endmodule

`default_nettype wire

// File: dummy_end.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// File: dbx_ref_model.sv
// Reference source model: quality flags and phase of the chosen input.
// Assumes the bench drives the fail bits at the falling edge.
`timescale 1ns/10ps
`default_nettype none
module dbx_ref_model
  import dbx_pkg::*;
(
  // Bench control
  input  wire logic [REF_COUNT-1:0] fail,
  // Block side
  input  wire logic [REF_W-1:0]     ref_select,
  output logic [REF_COUNT-1:0]      ref_valid,
  output logic [PH_W-1:0]           phase_err
);
  // Source drops out while its fail bit is set
  assign ref_valid = ~fail;
  // Each source sits at its own phase
  assign phase_err = {2'h0, ref_select, 12'h023};
endmodule
`default_nettype wire

// File: dbx_buildout_sva.sv
// Port assertions of the build-out block.
// Assumes the bench sets MEAS_LEN to 4.
`timescale 1ns/10ps
`default_nettype none
module dbx_buildout_sva
  import dbx_pkg::*;
#(
  parameter int unsigned MEAS_LEN = 4
) (
  // Clock and reset
  input wire logic            clk,
  input wire logic            reset_n,
  // Watched ports
  input wire dbx_host_t       host,
  input wire logic [REF_W-1:0] ref_select,
  input wire logic [PH_W-1:0] loop_phase,
  input wire logic [PH_W-1:0] pbo_offset,
  input wire logic            temp_holdover,
  input wire logic            pbo_event,
  input wire logic [15:0]     crystal_trim,
  input wire logic [16:0]     freq_adjust,
  input wire dbx_mode_t       pbo_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wr_lo_a: assert property (host.wr && !host.addr |=> crystal_trim[7:0] == $past(host.wdata))
    else $error("low trim byte lost");
  wr_hi_a: assert property (host.wr && host.addr |=> crystal_trim[15:8] == $past(host.wdata))
    else $error("high trim byte lost");
  adj_trim_a: assert property (freq_adjust == {1'b0, $past(crystal_trim)} - 17'h09999)
    else $error("frequency adjust off");
  ev_switch_a: assert property (pbo_event |-> temp_holdover
    && (ref_select != $past(ref_select) || $past(pbo_mode) == DBX_PBO_DISABLED))
    else $error("event without switch");
  hold_len_a: assert property ($rose(temp_holdover) |-> temp_holdover[*4] ##1 !temp_holdover)
    else $error("holdover length wrong");
  hold_zero_a: assert property (temp_holdover && $past(temp_holdover) |-> loop_phase == 16'h0000)
    else $error("loop phase moves in holdover");
  frozen_keep_a: assert property (pbo_mode == DBX_PBO_FROZEN && $past(pbo_mode) == DBX_PBO_FROZEN
    |-> $stable(pbo_offset) && !pbo_event) else $error("frozen offset changed");
  off_zero_a: assert property (pbo_mode == DBX_PBO_DISABLED |-> pbo_offset == 16'h0000 && !pbo_event)
    else $error("offset while disabled");
endmodule
bind dbx_buildout dbx_buildout_sva #(.MEAS_LEN(MEAS_LEN)) u_sva (.clk(clk), .reset_n(reset_n), .host(host),
  .ref_select(ref_select), .loop_phase(loop_phase), .pbo_offset(pbo_offset), .temp_holdover(temp_holdover),
  .pbo_event(pbo_event), .crystal_trim(crystal_trim), .freq_adjust(freq_adjust), .pbo_mode(pbo_mode));
`default_nettype wire

// File: tb_top.sv
// Bench of the build-out block: trim words, switchover per mode, bandwidth.
// Assumes the source model and checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import dbx_pkg::*;
;
  logic clk, reset_n, phase_locked, sel_ok, hold, pbo_event;
  dbx_host_t host;
  dbx_mode_t mode_req, pbo_mode;
  logic [3:0] acq_bw, locked_bw, active_bw;
  logic [REF_COUNT-1:0] fail, ref_valid;
  logic [PH_W-1:0] phase_err, loop_phase, pbo_offset;
  logic [REF_W-1:0] ref_select;
  logic [7:0] rdata;
  logic [15:0] trim;
  logic [16:0] adj;
  int fail_count = 0;
  int num_checks = 0;
  dbx_ref_model srcs (.fail(fail), .ref_select(ref_select), .ref_valid(ref_valid), .phase_err(phase_err));
  dbx_buildout #(.MEAS_LEN(4)) dut (.clk(clk), .reset_n(reset_n), .host(host), .host_rdata(rdata),
    .pbo_mode_req(mode_req), .acq_bw(acq_bw), .locked_bw(locked_bw), .ref_valid(ref_valid),
    .phase_locked(phase_locked), .phase_err(phase_err), .ref_select(ref_select), .ref_select_ok(sel_ok),
    .loop_phase(loop_phase), .pbo_offset(pbo_offset), .temp_holdover(hold), .pbo_event(pbo_event),
    .active_bw(active_bw), .crystal_trim(trim), .freq_adjust(adj), .pbo_mode(pbo_mode));
  task automatic chk(string name, logic [16:0] exp, logic [16:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic t_reset();
    step(2);
    chk("trim", 16'h9999, trim);
    chk("adj", 17'h00000, adj);
    chk("rdata", 8'h99, rdata);
    chk("mode", DBX_PBO_ENABLED, pbo_mode);
    chk("bw", 4'h9, active_bw);
    chk("sel", 2'h0, ref_select);
    chk("ok", 1'b1, sel_ok);
  endtask
  task automatic t_trim();
    logic [15:0] v [3] = '{16'h0000, 16'hFFFF, 16'h989A};
    logic [16:0] a [3] = '{17'h16667, 17'h06666, 17'h1FF01};
    foreach (v[i]) begin
      host = '{wr: 1'b1, addr: 1'b0, wdata: v[i][7:0]};
      step(1);
      host.addr = 1'b1;
      host.wdata = v[i][15:8];
      step(1);
      host.wr = 1'b0;
      step(2);
      chk("trim", v[i], trim);
      chk("adj", a[i], adj);
      chk("rdata", v[i][15:8], rdata);
    end
  endtask
  task automatic t_switch(dbx_mode_t m, logic [3:0] f, logic [1:0] s, logic ev, logic [15:0] off,
                          logic [15:0] lp);
    mode_req = m;
    step(2);
    chk("mode", m, pbo_mode);
    fail = f;
    step(1);
    chk("sel", s, ref_select);
    chk("event", ev, pbo_event);
    chk("hold", ev, hold);
    step(6);
    chk("hold", 1'b0, hold);
    chk("offset", off, pbo_offset);
    chk("loop", lp, loop_phase);
  endtask
  task automatic t_enable();
    mode_req = DBX_PBO_ENABLED;
    step(1);
    chk("event", 1'b1, pbo_event);
    chk("sel", 2'h3, ref_select);
    chk("hold", 1'b1, hold);
    step(6);
    chk("hold", 1'b0, hold);
    chk("offset", 16'h3023, pbo_offset);
    chk("loop", 16'h0000, loop_phase);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    reset_n = 1'b0;
    host = '0;
    mode_req = DBX_PBO_ENABLED;
    acq_bw = 4'hC;
    locked_bw = 4'h3;
    phase_locked = 1'b0;
    fail = '0;
    step(20);
    reset_n = 1'b1;
    t_reset();
    t_trim();
    phase_locked = 1'b1;
    t_switch(DBX_PBO_ENABLED, 4'b0001, 2'h1, 1'b1, 16'h1023, 16'h0000);
    chk("bw", 4'h3, active_bw);
    t_switch(DBX_PBO_FROZEN, 4'b0011, 2'h2, 1'b0, 16'h1023, 16'h1000);
    t_switch(DBX_PBO_DISABLED, 4'b0111, 2'h3, 1'b0, 16'h0000, 16'h3023);
    mode_req = DBX_PBO_FROZEN;
    step(2);
    chk("mode", DBX_PBO_DISABLED, pbo_mode);
    t_enable();
    give_verdict();
  end
  initial begin
    #100000;
    fail_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
